// *** accum_motion_pkg.sv ***
// constants, register map and frame layout of the accumulator motion command block
package accum_motion_pkg;
   // bus and data widths
   localparam int          DATA_W        = 32;
   localparam int          ADDR_W        = 8;
   localparam int          AXIS_W        = 3;
   localparam int          BYTE_W        = 8;
   localparam int          STORED_COORDINATE_TYPE_DEPTH   = 256;

   // register byte offsets
   localparam logic [7:0]  OFS_FRAME_HDR = 8'h00; // address, code, type, motor
   localparam logic [7:0]  OFS_FRAME_VAL = 8'h04; // value, msb first
   localparam logic [7:0]  OFS_FRAME_CHK = 8'h08; // checksum, write executes
   localparam logic [7:0]  OFS_ACCUM     = 8'h0c;
   localparam logic [7:0]  OFS_XREG      = 8'h10;
   localparam logic [7:0]  OFS_REPLY     = 8'h14;
   localparam logic [7:0]  OFS_STORED_COORDINATE_TYPE_IDX = 8'h18;
   localparam logic [7:0]  OFS_STORED_COORDINATE_TYPE_DAT = 8'h1c; // write stores a coordinate
   localparam logic [7:0]  OFS_AXIS_SEL  = 8'h20;
   localparam logic [7:0]  OFS_AXIS_TPOS = 8'h24;
   localparam logic [7:0]  OFS_AXIS_TVEL = 8'h28;
   localparam logic [7:0]  OFS_AXIS_STAT = 8'h2c;

   // frame byte positions inside the header word
   localparam int          FR_ADDR_LSB   = 24;
   localparam int          FR_CODE_LSB   = 16;
   localparam int          FR_TYPE_LSB   = 8;
   localparam int          FR_MOTOR_LSB  = 0;

   // instruction codes of this group
   localparam logic [7:0]  CODE_MOVE_ACC     = 8'h2e; // move_to_accum_position
   localparam logic [7:0]  CODE_MOVE_ACC_IDX = 8'h2f; // move_to_accum_position_indexed
   localparam logic [7:0]  CODE_ROT_LEFT_ACC = 8'h32; // rotate_left_accum_velocity
   localparam logic [7:0]  CODE_ROT_RIGHT_ACC= 8'h33; // rotate_right_accum_velocity

   // move types
   localparam logic [7:0]  TYPE_ABSOLUTE = 8'h00; // absolute_target_type
   localparam logic [7:0]  TYPE_RELATIVE = 8'h01; // relative_offset_type
   localparam logic [7:0]  TYPE_STORED   = 8'h02; // stored_coordinate_type
   localparam logic [7:0]  MAX_AXIS_IDX  = 8'h05;

   // reply status codes
   localparam logic [7:0]  STATUS_OK      = 8'h64;
   localparam logic [7:0]  STATUS_BAD_SUM = 8'h01;
   localparam logic [7:0]  STATUS_BAD_CMD = 8'h02;
   localparam logic [7:0]  STATUS_BAD_TYPE= 8'h03;
   localparam logic [7:0]  STATUS_BAD_VAL = 8'h04;

   // reply and axis status bit positions
   localparam int          REPLY_VALID_BIT = 8;
   localparam int          REPLY_BUSY_BIT  = 9;
   localparam int          STAT_VMODE_BIT  = 0;
   localparam int          STAT_MOVING_BIT = 1;
   localparam int          STAT_UP_BIT     = 2;

   // axi response codes and reset values
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;

   typedef enum logic { ST_IDLE, ST_EXEC } exec_state_e;
endpackage

// *** accum_motion_cmd.sv ***
// accumulator motion command interpreter with axi4-lite register access
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module accum_motion_cmd
   import accum_motion_pkg::*;
#(
   parameter int          NUM_AXES    = 6,
   parameter logic [7:0]  DEVICE_ADDR = 8'h01 // arbitrary module address
)(
   input  wire logic                                 mclk_i,
   input  wire logic                                 resetn_i,
   input  wire logic [accum_motion_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
   input  wire logic                                 s_axi_awvalid_i,
   output logic                                      s_axi_awready_o,
   input  wire logic [accum_motion_pkg::DATA_W-1:0]  s_axi_wdata_i,
   input  wire logic [3:0]                           s_axi_wstrb_i,
   input  wire logic                                 s_axi_wvalid_i,
   output logic                                      s_axi_wready_o,
   output logic [1:0]                                s_axi_bresp_o,
   output logic                                      s_axi_bvalid_o,
   input  wire logic                                 s_axi_bready_i,
   input  wire logic [accum_motion_pkg::ADDR_W-1:0]  s_axi_araddr_i,
   input  wire logic                                 s_axi_arvalid_i,
   output logic                                      s_axi_arready_o,
   output logic [accum_motion_pkg::DATA_W-1:0]       s_axi_rdata_o,
   output logic [1:0]                                s_axi_rresp_o,
   output logic                                      s_axi_rvalid_o,
   input  wire logic                                 s_axi_rready_i,
   input  wire logic [NUM_AXES*accum_motion_pkg::DATA_W-1:0] actual_pos_i,
   input  wire logic [NUM_AXES-1:0]                  at_target_i,
   output logic                                      eng_load_o,
   output logic [accum_motion_pkg::AXIS_W-1:0]       eng_axis_o,
   output logic [accum_motion_pkg::DATA_W-1:0]       eng_value_o,
   output logic                                      eng_vel_mode_o,
   output logic                                      eng_dir_up_o
);
   import accum_motion_pkg::*;

   // merge byte lanes of a write into an old word
   function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [3:0]        strb);
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
      return res;
   endfunction

   // bus handshake state
   logic              awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
   logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic              arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata, rd_word;
   logic              wr_en, rd_en, wr_hit, rd_hit;

   // software registers
   logic [DATA_W-1:0] hdr_ff, nxt_hdr, val_ff, nxt_val, accum_ff, nxt_accum, xreg_ff, nxt_xreg;
   logic [7:0]        chk_ff, nxt_chk, stored_coordinate_type_idx_ff, nxt_stored_coordinate_type_idx, status_ff, nxt_status;
   logic [AXIS_W-1:0] axis_sel_ff, nxt_axis_sel;
   logic              reply_valid_ff, nxt_reply_valid, go, stored_coordinate_type_wr;
   logic [DATA_W-1:0] stored_coordinate_type_mem [STORED_COORDINATE_TYPE_DEPTH];

   // execution state and engine outputs
   exec_state_e       state_ff, nxt_state;
   logic              load_ff, nxt_load, vmode_out_ff, nxt_vmode_out, up_ff, nxt_up;
   logic [AXIS_W-1:0] eaxis_ff, nxt_eaxis;
   logic [DATA_W-1:0] evalue_ff, nxt_evalue;

   // decode results
   logic [7:0]        f_addr, f_code, f_type, f_motor, f_sum, ex_status;
   logic              ex_run, ex_ok, ex_pos, ex_vel, ex_up;
   logic [AXIS_W-1:0] ex_axis;
   logic [7:0]        ex_axis8;
   logic [DATA_W-1:0] ex_value, act_pos, rel_sum;

   // per-axis parameters
   logic [DATA_W-1:0] tpos_ff [NUM_AXES];
   logic [DATA_W-1:0] tvel_ff [NUM_AXES];
   logic [NUM_AXES-1:0] vmode_ff, moving_ff, dirup_ff;

   // axi write and read channel handshakes; address and data are taken together
   always_comb
   begin
      wr_en       = awready_ff && s_axi_awvalid_i && s_axi_wvalid_i;
      rd_en       = arready_ff && s_axi_arvalid_i;
      nxt_awready = s_axi_awvalid_i && s_axi_wvalid_i && !awready_ff && !bvalid_ff;
      nxt_wready  = nxt_awready;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      if (wr_en)
      begin
         nxt_bvalid = 1'b1;
         nxt_bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready_i)
         nxt_bvalid = 1'b0;
      nxt_arready = s_axi_arvalid_i && !arready_ff && !rvalid_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      if (rd_en)
      begin
         nxt_rvalid = 1'b1;
         nxt_rdata  = rd_hit ? rd_word : ZERO_WORD;
         nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready_i)
         nxt_rvalid = 1'b0;
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= ZERO_WORD;
         rresp_ff   <= RESP_OKAY;
      end
      else
      begin
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end
   end

   // read mux over the register map
   always_comb
   begin
      rd_hit  = 1'b1;
      rd_word = ZERO_WORD;
      case (s_axi_araddr_i)
         OFS_FRAME_HDR: rd_word = hdr_ff;
         OFS_FRAME_VAL: rd_word = val_ff;
         OFS_FRAME_CHK: rd_word[7:0] = chk_ff;
         OFS_ACCUM:     rd_word = accum_ff;
         OFS_XREG:      rd_word = xreg_ff;
         OFS_REPLY:
         begin
            rd_word[7:0]           = status_ff;
            rd_word[REPLY_VALID_BIT] = reply_valid_ff;
            rd_word[REPLY_BUSY_BIT]  = (state_ff == ST_EXEC);
         end
         OFS_STORED_COORDINATE_TYPE_IDX: rd_word[7:0] = stored_coordinate_type_idx_ff;
         OFS_STORED_COORDINATE_TYPE_DAT: rd_word = stored_coordinate_type_mem[stored_coordinate_type_idx_ff];
         OFS_AXIS_SEL:  rd_word[AXIS_W-1:0] = axis_sel_ff;
         OFS_AXIS_TPOS: rd_word = tpos_ff[axis_sel_ff];
         OFS_AXIS_TVEL: rd_word = tvel_ff[axis_sel_ff];
         OFS_AXIS_STAT:
         begin
            rd_word[STAT_VMODE_BIT]  = vmode_ff[axis_sel_ff];
            rd_word[STAT_MOVING_BIT] = moving_ff[axis_sel_ff];
            rd_word[STAT_UP_BIT]     = dirup_ff[axis_sel_ff];
         end
         default:       rd_hit = 1'b0;
      endcase
   end

   // register writes; checksum write launches execution of the latched frame
   always_comb
   begin
      wr_hit        = 1'b1;
      go            = 1'b0;
      stored_coordinate_type_wr      = 1'b0;
      nxt_hdr       = hdr_ff;
      nxt_val       = val_ff;
      nxt_chk       = chk_ff;
      nxt_accum     = accum_ff;
      nxt_xreg      = xreg_ff;
      nxt_stored_coordinate_type_idx = stored_coordinate_type_idx_ff;
      nxt_axis_sel  = axis_sel_ff;
      case (s_axi_awaddr_i)
         OFS_FRAME_HDR: nxt_hdr = merge_strb(hdr_ff, s_axi_wdata_i, s_axi_wstrb_i);
         OFS_FRAME_VAL: nxt_val = merge_strb(val_ff, s_axi_wdata_i, s_axi_wstrb_i);
         OFS_FRAME_CHK:
         begin
            nxt_chk = s_axi_wstrb_i[0] ? s_axi_wdata_i[7:0] : chk_ff;
            go      = wr_en && (state_ff == ST_IDLE);
         end
         OFS_ACCUM:     nxt_accum = merge_strb(accum_ff, s_axi_wdata_i, s_axi_wstrb_i);
         OFS_XREG:      nxt_xreg  = merge_strb(xreg_ff, s_axi_wdata_i, s_axi_wstrb_i);
         OFS_STORED_COORDINATE_TYPE_IDX: nxt_stored_coordinate_type_idx = s_axi_wstrb_i[0] ? s_axi_wdata_i[7:0] : stored_coordinate_type_idx_ff;
         OFS_STORED_COORDINATE_TYPE_DAT: stored_coordinate_type_wr = wr_en;
         OFS_AXIS_SEL:  nxt_axis_sel = s_axi_wstrb_i[0] ? s_axi_wdata_i[AXIS_W-1:0] : axis_sel_ff;
         default:       wr_hit = 1'b0;
      endcase
      if (!wr_en)
      begin
         nxt_hdr = hdr_ff; nxt_val = val_ff; nxt_chk = chk_ff; nxt_accum = accum_ff;
         nxt_xreg = xreg_ff; nxt_stored_coordinate_type_idx = stored_coordinate_type_idx_ff; nxt_axis_sel = axis_sel_ff;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         hdr_ff       <= ZERO_WORD;
         val_ff       <= ZERO_WORD;
         chk_ff       <= ZERO_BYTE;
         accum_ff     <= ZERO_WORD;
         xreg_ff      <= ZERO_WORD;
         stored_coordinate_type_idx_ff <= ZERO_BYTE;
         axis_sel_ff  <= '0;
      end
      else
      begin
         hdr_ff       <= nxt_hdr;
         val_ff       <= nxt_val;
         chk_ff       <= nxt_chk;
         accum_ff     <= nxt_accum;
         xreg_ff      <= nxt_xreg;
         stored_coordinate_type_idx_ff <= nxt_stored_coordinate_type_idx;
         axis_sel_ff  <= nxt_axis_sel;
      end
   end

   // coordinate store, no reset needed for storage
   always_ff @(posedge mclk_i)
   begin
      if (stored_coordinate_type_wr)
         stored_coordinate_type_mem[stored_coordinate_type_idx_ff] <= merge_strb(stored_coordinate_type_mem[stored_coordinate_type_idx_ff], s_axi_wdata_i, s_axi_wstrb_i);
   end

   // frame decode and command checks during the execute cycle
   always_comb
   begin
      f_addr    = hdr_ff[FR_ADDR_LSB +: BYTE_W];
      f_code    = hdr_ff[FR_CODE_LSB +: BYTE_W];
      f_type    = hdr_ff[FR_TYPE_LSB +: BYTE_W];
      f_motor   = hdr_ff[FR_MOTOR_LSB +: BYTE_W];
      f_sum     = f_addr + f_code + f_type + f_motor + val_ff[31:24] + val_ff[23:16]
                  + val_ff[15:8] + val_ff[7:0];
      ex_run    = (state_ff == ST_EXEC) && (f_addr == DEVICE_ADDR);
      ex_status = STATUS_OK;
      ex_pos    = 1'b0;
      ex_vel    = 1'b0;
      ex_up     = 1'b0;
      ex_axis8  = (f_code == CODE_MOVE_ACC_IDX) ? xreg_ff[7:0] : f_motor;
      ex_axis   = ex_axis8[AXIS_W-1:0];
      act_pos   = actual_pos_i[ex_axis*DATA_W +: DATA_W];
      rel_sum   = act_pos + accum_ff;
      ex_value  = accum_ff;
      if (f_sum != chk_ff)
         ex_status = STATUS_BAD_SUM;
      else
         case (f_code)
            CODE_MOVE_ACC, CODE_MOVE_ACC_IDX:
            begin
               ex_pos = 1'b1;
               if (f_type == TYPE_STORED && f_code == CODE_MOVE_ACC)
               begin
                  ex_axis  = xreg_ff[AXIS_W-1:0];
                  ex_axis8 = xreg_ff[7:0];
                  ex_value = stored_coordinate_type_mem[f_motor];
               end
               else if (f_type == TYPE_STORED)
                  ex_value = stored_coordinate_type_mem[stored_coordinate_type_idx_ff];
               else if (f_type == TYPE_RELATIVE)
                  ex_value = act_pos + accum_ff;
               else if (f_type != TYPE_ABSOLUTE)
                  ex_status = STATUS_BAD_TYPE;
               if (ex_axis8 > MAX_AXIS_IDX)
                  ex_status = STATUS_BAD_VAL;
            end
            CODE_ROT_LEFT_ACC, CODE_ROT_RIGHT_ACC:
            begin
               ex_vel = 1'b1;
               ex_up  = (f_code == CODE_ROT_RIGHT_ACC);
               if (f_motor > MAX_AXIS_IDX)
                  ex_status = STATUS_BAD_VAL;
            end
            default: ex_status = STATUS_BAD_CMD;
         endcase
      ex_ok = ex_run && (ex_status == STATUS_OK);
   end

   // execute sequencer, reply and engine handoff
   always_comb
   begin
      nxt_state       = state_ff;
      nxt_status      = status_ff;
      nxt_reply_valid = reply_valid_ff;
      nxt_load        = 1'b0;
      nxt_eaxis       = eaxis_ff;
      nxt_evalue      = evalue_ff;
      nxt_vmode_out   = vmode_out_ff;
      nxt_up          = up_ff;
      case (state_ff)
         ST_IDLE:
            if (go)
            begin
               nxt_state       = ST_EXEC;
               nxt_reply_valid = 1'b0;
            end
         ST_EXEC:
         begin
            nxt_state = ST_IDLE;
            if (ex_run)
            begin
               nxt_status      = ex_status;
               nxt_reply_valid = 1'b1;
            end
            if (ex_ok)
            begin
               nxt_load      = 1'b1;
               nxt_eaxis     = ex_axis;
               nxt_evalue    = ex_value;
               nxt_vmode_out = ex_vel;
               nxt_up        = ex_vel ? ex_up : 1'b0;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_ff       <= ST_IDLE;
         status_ff      <= ZERO_BYTE;
         reply_valid_ff <= 1'b0;
         load_ff        <= 1'b0;
         eaxis_ff       <= '0;
         evalue_ff      <= ZERO_WORD;
         vmode_out_ff   <= 1'b0;
         up_ff          <= 1'b0;
      end
      else
      begin
         state_ff       <= nxt_state;
         status_ff      <= nxt_status;
         reply_valid_ff <= nxt_reply_valid;
         load_ff        <= nxt_load;
         eaxis_ff       <= nxt_eaxis;
         evalue_ff      <= nxt_evalue;
         vmode_out_ff   <= nxt_vmode_out;
         up_ff          <= nxt_up;
      end
   end

   // per-axis parameter copies; a rotate ends the move in progress on its own axis
   for (genvar a = 0; a < NUM_AXES; a++)
   begin : g_axis
      logic              hit, nxt_vm, nxt_mv, nxt_du;
      logic [DATA_W-1:0] nxt_tp, nxt_tv;
      always_comb
      begin
         hit    = ex_ok && (ex_axis == AXIS_W'(a));
         nxt_tp = tpos_ff[a];
         nxt_tv = tvel_ff[a];
         nxt_vm = vmode_ff[a];
         nxt_du = dirup_ff[a];
         // the engine still shows its old arrival while our load pulse is in flight
         nxt_mv = moving_ff[a] && (!at_target_i[a] || (load_ff && eaxis_ff == AXIS_W'(a)));
         if (hit && ex_pos)
         begin
            nxt_tp = ex_value;
            nxt_vm = 1'b0;
            nxt_mv = 1'b1;
         end
         else if (hit && ex_vel)
         begin
            nxt_vm = 1'b1;
            nxt_tv = accum_ff;
            nxt_du = ex_up;
            nxt_mv = 1'b0;
         end
      end
      always_ff @(posedge mclk_i or negedge resetn_i)
      begin
         if (!resetn_i)
         begin
            tpos_ff[a]   <= ZERO_WORD;
            tvel_ff[a]   <= ZERO_WORD;
            vmode_ff[a]  <= 1'b0;
            moving_ff[a] <= 1'b0;
            dirup_ff[a]  <= 1'b0;
         end
         else
         begin
            tpos_ff[a]   <= nxt_tp;
            tvel_ff[a]   <= nxt_tv;
            vmode_ff[a]  <= nxt_vm;
            moving_ff[a] <= nxt_mv;
            dirup_ff[a]  <= nxt_du;
         end
      end
   end

   // port drive straight from flops
   assign s_axi_awready_o = awready_ff;
   assign s_axi_wready_o  = wready_ff;
   assign s_axi_bvalid_o  = bvalid_ff;
   assign s_axi_bresp_o   = bresp_ff;
   assign s_axi_arready_o = arready_ff;
   assign s_axi_rvalid_o  = rvalid_ff;
   assign s_axi_rdata_o   = rdata_ff;
   assign s_axi_rresp_o   = rresp_ff;
   assign eng_load_o      = load_ff;
   assign eng_axis_o      = eaxis_ff;
   assign eng_value_o     = evalue_ff;
   assign eng_vel_mode_o  = vmode_out_ff;
   assign eng_dir_up_o    = up_ff;

   // checks on the command path
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   chk_go_reply: assert property (go |=> (state_ff == ST_EXEC) ##1 (state_ff == ST_IDLE))
      else $error("execute cycle did not finish in one cycle");
   chk_reply_ok: assert property (ex_ok |=> reply_valid_ff && status_ff == STATUS_OK)
      else $error("accepted command not answered with ok status");
   chk_abs_target: assert property (ex_ok && ex_pos && f_type == TYPE_ABSOLUTE |=>
                                    eng_value_o == $past(accum_ff))
      else $error("absolute move target is not the accumulator");
   chk_rel_wrap: assert property (ex_ok && ex_pos && f_type == TYPE_RELATIVE |=>
                                  eng_value_o == $past(rel_sum))
      else $error("relative move target is not the wrapped sum");
   chk_left_down: assert property (ex_ok && f_code == CODE_ROT_LEFT_ACC |=>
                                   eng_vel_mode_o && !eng_dir_up_o && eng_load_o)
      else $error("rotate left not issued downward in velocity mode");
   chk_right_up: assert property (ex_ok && f_code == CODE_ROT_RIGHT_ACC |=>
                                  eng_vel_mode_o && eng_dir_up_o)
      else $error("rotate right not issued upward in velocity mode");
   chk_rot_abandon: assert property (ex_ok && ex_vel |=> !moving_ff[eng_axis_o])
      else $error("rotate did not abandon the move");
   chk_bad_reject: assert property (ex_run && !ex_ok |=> !eng_load_o && status_ff != STATUS_OK)
      else $error("rejected command reached the engine");
   chk_index_axis: assert property (ex_ok && f_code == CODE_MOVE_ACC_IDX |=>
                                    eng_axis_o == $past(xreg_ff[AXIS_W-1:0]))
      else $error("indexed move used the wrong axis");
endmodule // accum_motion_cmd

// *** engine_model.sv ***
// motion engine stand-in: fixed actual positions, travel time after each load
`timescale 1ns/1ps
module engine_model
(
   input  wire logic    mclk_i,
   input  wire logic    resetn_i,
   input  wire logic    load_i,
   output logic [191:0] actual_pos_o,
   output logic [5:0]   at_target_o
);
   logic [5:0] nxt_cnt, cnt_ff;
   // axis a stands at 8000_0000 plus 16 times a
   for (genvar a = 0; a < 6; a++) assign actual_pos_o[a*32+:32] = 32'h8000_0000 + 32'(a * 16);
   // axes stay off target for a while after a load, so commands arrive mid-travel
   assign nxt_cnt = load_i ? 6'h3c : cnt_ff - 6'(cnt_ff != 6'h00);
   always_ff @(posedge mclk_i or negedge resetn_i)
      if (!resetn_i) cnt_ff <= 6'h00;
      else cnt_ff <= nxt_cnt;
   assign at_target_o = {6{cnt_ff == 6'h00}};
endmodule // engine_model

// *** accum_motion_commands_tb_top.sv ***
// self-checking bench for the accumulator motion command interpreter
`timescale 1ns/1ps
module accum_motion_commands_tb_top;
   import accum_motion_pkg::*;
   typedef struct packed {logic [7:0] code, typ, mot, xr; logic [31:0] acc; logic [7:0] st;
      logic ld; logic [2:0] ax; logic [31:0] val; logic vm, up;} row_s;
   logic mclk_i = 0, resetn_i = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rd, rdata, val, c_val;
   logic [1:0] bresp, rresp, resp;
   logic awready, wready, bvalid, arready, rvalid, ld, vm, up, c_vm, c_up;
   logic [2:0] ax, c_ax;
   logic [191:0] apos;
   logic [5:0] att;
   int n_fail = 0, check_count = 0, n_load = 0, cyc = 0, nl;
   row_s rows [11] = '{
      '{8'h2e,8'h00,8'h03,8'h00,32'h12345678,8'h64,1'h1,3'h3,32'h12345678,1'h0,1'h0},
      '{8'h2e,8'h01,8'h01,8'h00,32'h0000000a,8'h64,1'h1,3'h1,32'h8000001a,1'h0,1'h0},
      '{8'h2e,8'h01,8'h02,8'h00,32'h7fffffff,8'h64,1'h1,3'h2,32'h0000001f,1'h0,1'h0},
      '{8'h2f,8'h00,8'h09,8'h04,32'h00000777,8'h64,1'h1,3'h4,32'h00000777,1'h0,1'h0},
      '{8'h2e,8'h02,8'h07,8'h02,32'h00000001,8'h64,1'h1,3'h2,32'h00c0ffee,1'h0,1'h0},
      '{8'h32,8'h05,8'h05,8'h00,32'h00000300,8'h64,1'h1,3'h5,32'h00000300,1'h1,1'h0},
      '{8'h33,8'h00,8'h00,8'h00,32'h00000400,8'h64,1'h1,3'h0,32'h00000400,1'h1,1'h1},
      '{8'h2e,8'h00,8'h06,8'h00,32'h00000010,8'h04,1'h0,3'h0,32'h00000000,1'h0,1'h0},
      '{8'h2f,8'h02,8'h00,8'h01,32'h00000005,8'h64,1'h1,3'h1,32'h00c0ffee,1'h0,1'h0},
      '{8'h2e,8'h03,8'h00,8'h00,32'h00000005,8'h03,1'h0,3'h0,32'h00000000,1'h0,1'h0},
      '{8'h30,8'h00,8'h00,8'h00,32'h00000010,8'h02,1'h0,3'h0,32'h00000000,1'h0,1'h0}};
   accum_motion_cmd uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .actual_pos_i(apos),
      .at_target_i(att), .eng_load_o(ld), .eng_axis_o(ax), .eng_value_o(val), .eng_vel_mode_o(vm),
      .eng_dir_up_o(up));
   engine_model eng (.mclk_i(mclk_i), .resetn_i(resetn_i), .load_i(ld), .actual_pos_o(apos), .at_target_o(att));
   // bus tasks hold each channel until its ready is sampled high
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
      do @(posedge mclk_i); while (awready !== 1'b1);
      awv <= 0; wv <= 0;
      chk("wready", 32'(wready), 32'h1);
      do @(posedge mclk_i); while (bvalid !== 1'b1);
      bready <= 0; resp = bresp;
      chk("bresp", 32'(resp), 32'(RESP_OKAY));
      @(posedge mclk_i);
   endtask
   task automatic rdr(input logic [7:0] a);
      araddr <= a; arv <= 1; rready <= 1;
      do @(posedge mclk_i); while (arready !== 1'b1);
      arv <= 0;
      do @(posedge mclk_i); while (rvalid !== 1'b1);
      rready <= 0; rd = rdata; resp = rresp;
      @(posedge mclk_i);
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin n_fail++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end
   endtask
   // one frame with value field 0bad_0bad; bad adds an error to the checksum
   task automatic cmd(input logic [7:0] code, typ, mot, bad);
      wr(OFS_FRAME_HDR, {8'h01, code, typ, mot});
      wr(OFS_FRAME_VAL, 32'h0bad_0bad);
      wr(OFS_FRAME_CHK, {24'h0, 8'h71 + code + typ + mot + bad});
      do rdr(OFS_REPLY); while (rd[8] !== 1'b1);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // clock, cycle limit and engine-load capture
   initial forever #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
   begin
      cyc++;
      if (ld === 1'b1) begin n_load++; c_ax = ax; c_val = val; c_vm = vm; c_up = up; end
      if (cyc == 20000) begin n_fail++; report_and_stop; end
   end
   // table rows, then a move cut by a rotate, bad checksum, unmapped read, reset
   initial
   begin
      repeat (5) @(posedge mclk_i);
      resetn_i <= 1;
      @(posedge mclk_i);
      wr(OFS_STORED_COORDINATE_TYPE_IDX, 32'h7);
      wr(OFS_STORED_COORDINATE_TYPE_DAT, 32'h00c0_ffee);
      foreach (rows[i])
      begin
         wr(OFS_ACCUM, rows[i].acc);
         wr(OFS_XREG, {24'h0, rows[i].xr});
         nl = n_load;
         cmd(rows[i].code, rows[i].typ, rows[i].mot, 8'h0);
         chk("status", rd[7:0], rows[i].st);
         chk("loads", 32'(n_load - nl), 32'(rows[i].ld));
         if (rows[i].ld) chk("axis", c_ax, rows[i].ax);
         if (rows[i].ld) chk("value", c_val, rows[i].val);
         if (rows[i].ld) chk("mode", c_vm, rows[i].vm);
         if (rows[i].vm) chk("dir", c_up, rows[i].up);
         $display("row %0d done", i);
      end
      wr(OFS_AXIS_SEL, 32'h3);
      cmd(CODE_MOVE_ACC, TYPE_ABSOLUTE, 8'h03, 8'h0);
      rdr(OFS_AXIS_STAT);
      chk("moving", rd[2:0], 3'h2);
      cmd(CODE_ROT_RIGHT_ACC, 8'h0, 8'h03, 8'h0);
      rdr(OFS_AXIS_STAT);
      chk("abandon", rd[2:0], 3'h5);
      nl = n_load;
      cmd(CODE_MOVE_ACC, TYPE_ABSOLUTE, 8'h00, 8'h01);
      chk("bad sum", {rd[7:0], 8'(n_load - nl)}, {STATUS_BAD_SUM, 8'h0});
      nl = n_load;
      wr(OFS_FRAME_HDR, {8'h02, CODE_MOVE_ACC, 8'h00, 8'h00});
      wr(OFS_FRAME_CHK, 32'h0000_00a0);
      rdr(OFS_REPLY);
      chk("foreign", 32'({rd[8], 8'(n_load - nl)}), 32'h0);
      rdr(8'h40);
      chk("unmapped", rd, ZERO_WORD);
      chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
      $display("hand tests done");
      resetn_i <= 0;
      @(posedge mclk_i);
      chk("reset value", val, ZERO_WORD);
      chk("reset flags", 32'({ld, vm, up, ax}), 32'h0);
      report_and_stop;
   end
endmodule // accum_motion_commands_tb_top
